// File: logic/bridge_sec_pkg.sv
package bridge_sec_pkg;
   localparam logic [7:0] status_offset = 8'h1c;
   localparam logic [7:0] membase_offset = 8'h20;
   localparam logic [15:0] status_reset = 16'h02a0;
   localparam logic [15:0] membase_reset = 16'h0000;
   localparam logic [15:0] status_const = 16'h02a0;
   localparam int flag_lsb = 8;
   localparam int base_lsb = 4;
   localparam logic [1:0] devsel_medium = 2'h1;

   typedef struct packed {
      logic detected_parity_flag;
      logic received_system_error_flag;
      logic received_master_abort_flag;
      logic received_target_abort_flag;
      logic signalled_target_abort_flag;
      logic master_data_parity_flag;
   } event_type;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] offset;
      logic [3:0] byte_enable_n;
      logic [31:0] data;
   } cfg_req_type;
endpackage : bridge_sec_pkg

// File: logic/w1c_flag.sv
module w1c_flag
   import bridge_sec_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_arst_n,
   input wire logic i_set,
   input wire logic i_clear,
   output logic o_flag
);
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_flag <= 1'b0;
      end else if (i_set) begin
         o_flag <= 1'b1;
      end else if (i_clear) begin
         o_flag <= 1'b0;
      end
   end

   a_set_wins: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_set |=> o_flag)
      else $error("flag lost its set");
   a_clear_only: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (i_clear && !i_set) |=> !o_flag)
      else $error("flag not cleared");
   a_hold_idle: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (!i_clear && !i_set) |=> $stable(o_flag))
      else $error("flag changed idle");
endmodule : w1c_flag

// File: logic/bridge_secondary_status_membase.sv
module bridge_secondary_status_membase
   import bridge_sec_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_arst_n,
   input wire cfg_req_type i_cfg,
   input wire logic i_address_parity_error,
   input wire logic i_data_parity_error,
   input wire logic i_secondary_system_error_line_n,
   input wire logic i_secondary_parity_error_line_n,
   input wire logic i_primary_parity_error,
   input wire logic i_secondary_master_active,
   input wire logic i_master_abort_received,
   input wire logic i_target_abort_received,
   input wire logic i_target_abort_signalled,
   input wire logic i_parity_error_response,
   input wire logic [11:0] i_memory_limit,
   input wire logic [31:0] i_secondary_address,
   output logic [31:0] o_read_data,
   output logic o_read_valid,
   output logic [31:0] o_window_base,
   output logic [31:0] o_window_limit,
   output logic o_window_hit,
   output logic [1:0] o_devsel_timing
);
   ////////////////////////////////////////////////////////////
   event_type set_vec;
   event_type clr_vec;
   event_type flags;
   logic status_write;
   logic base_write;
   logic status_read;
   logic base_read;
   logic [11:0] base_field;

   // one request decoded against direction and offset
   function automatic logic is_access(input cfg_req_type r, input logic w, input logic [7:0] off);
      return r.valid && r.write == w && r.offset == off;
   endfunction : is_access

   // window bounds at 1MB granularity
   function automatic logic [31:0] lower_bound(input logic [11:0] field);
      return {field, 20'h00000};
   endfunction : lower_bound

   function automatic logic [31:0] upper_bound(input logic [11:0] field);
      return {field, 20'hfffff};
   endfunction : upper_bound

   assign status_write = is_access(i_cfg, 1'b1, status_offset);
   assign base_write = is_access(i_cfg, 1'b1, membase_offset);
   assign status_read = is_access(i_cfg, 1'b0, status_offset);
   assign base_read = is_access(i_cfg, 1'b0, membase_offset);

   always_comb begin
      set_vec.detected_parity_flag = i_address_parity_error || i_data_parity_error;
      set_vec.received_system_error_flag = !i_secondary_system_error_line_n;
      set_vec.received_master_abort_flag = i_master_abort_received;
      set_vec.received_target_abort_flag = i_target_abort_received;
      set_vec.signalled_target_abort_flag = i_target_abort_signalled;
      set_vec.master_data_parity_flag = i_secondary_master_active && i_parity_error_response
         && (!i_secondary_parity_error_line_n || i_primary_parity_error);
   end

   // upper status byte enabled by lane 3 low
   always_comb begin
      clr_vec = '0;
      if (status_write && !i_cfg.byte_enable_n[3]) begin
         clr_vec = {i_cfg.data[31:27], i_cfg.data[24]};
      end
   end

   for (genvar g = 0; g < 6; g++) begin : g_flag
      w1c_flag u_flag (
         .i_clock(i_clock),
         .i_arst_n(i_arst_n),
         .i_set(set_vec[g]),
         .i_clear(clr_vec[g]),
         .o_flag(flags[g])
      );
   end

   ////////////////////////////////////////////////////////////
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         base_field <= membase_reset[15:base_lsb];
      end else if (base_write) begin
         if (!i_cfg.byte_enable_n[0]) begin
            base_field[3:0] <= i_cfg.data[7:4];
         end
         if (!i_cfg.byte_enable_n[1]) begin
            base_field[11:4] <= i_cfg.data[15:8];
         end
      end
   end

   function automatic logic [31:0] status_word(input event_type f);
      logic [15:0] s;
      s = status_const;
      s[15:11] = {f.detected_parity_flag, f.received_system_error_flag, f.received_master_abort_flag,
         f.received_target_abort_flag, f.signalled_target_abort_flag};
      s[8] = f.master_data_parity_flag;
      return {s, 16'h0000};
   endfunction : status_word

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_read_data <= 32'h0000_0000;
         o_read_valid <= 1'b0;
      end else begin
         o_read_valid <= i_cfg.valid && !i_cfg.write;
         if (status_read) begin
            o_read_data <= status_word(flags);
         end else if (base_read) begin
            o_read_data <= {16'h0000, base_field, 4'h0};
         end else begin
            o_read_data <= 32'h0000_0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_window_base <= 32'h0000_0000;
         o_window_limit <= 32'h000f_ffff;
         o_window_hit <= 1'b0;
         o_devsel_timing <= devsel_medium;
      end else begin
         o_window_base <= lower_bound(base_field);
         o_window_limit <= upper_bound(i_memory_limit);
         o_window_hit <= i_secondary_address >= lower_bound(base_field)
            && i_secondary_address <= upper_bound(i_memory_limit);
         o_devsel_timing <= devsel_medium;
      end
   end

   ////////////////////////////////////////////////////////////
   // each event source sets its flag one edge later
   a_parity_sets: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_data_parity_error |=> flags.detected_parity_flag)
      else $error("parity flag not set");
   a_addr_parity: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_address_parity_error |=> flags.detected_parity_flag)
      else $error("address parity flag not set");
   a_serr_sets: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      !i_secondary_system_error_line_n |=> flags.received_system_error_flag)
      else $error("serr flag");
   a_mabort_sets: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_master_abort_received |=> flags.received_master_abort_flag)
      else $error("master abort flag");
   a_tabort_sets: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_target_abort_received |=> flags.received_target_abort_flag)
      else $error("target abort flag");
   a_sig_abort: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_target_abort_signalled |=> flags.signalled_target_abort_flag)
      else $error("signalled abort");
   a_mdp_sets: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (i_secondary_master_active && i_parity_error_response
      && (!i_secondary_parity_error_line_n || i_primary_parity_error)) |=> flags.master_data_parity_flag)
      else $error("data parity flag not set");
   a_mdp_gate: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (!i_parity_error_response && !flags.master_data_parity_flag) |=> !flags.master_data_parity_flag)
      else $error("data parity flag set without enable");
   a_mdp_master: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (!i_secondary_master_active && !flags.master_data_parity_flag) |=> !flags.master_data_parity_flag)
      else $error("data parity flag set while not master");
   // software clears only through lane 3, and a set outranks the clear
   a_clear_works: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (status_write && !i_cfg.byte_enable_n[3] && i_cfg.data[29] && !set_vec.received_master_abort_flag)
      |=> !flags.received_master_abort_flag)
      else $error("master abort flag not cleared");
   a_lane_gate: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (status_write && i_cfg.byte_enable_n[3] && set_vec == '0) |=> $stable(flags))
      else $error("flags changed without lane 3");
   a_set_beats_clear: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (set_vec.detected_parity_flag && clr_vec.detected_parity_flag) |=> flags.detected_parity_flag)
      else $error("clear won over a set");
   // fixed and reserved bits of the status word
   a_const_bits: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      status_read |=> o_read_data[26:25] == devsel_medium)
      else $error("constant status bits wrong");
   a_back_to_back: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      status_read |=> o_read_data[23])
      else $error("fast back-to-back bit low");
   a_speed_bit: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      status_read |=> o_read_data[21])
      else $error("speed bit low");
   a_no_cap_list: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      status_read |=> !o_read_data[20])
      else $error("capability list bit high");
   a_reserved_zero: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      status_read |=> (!o_read_data[22] && o_read_data[19:16] == 4'h0))
      else $error("reserved status bits not zero");
   a_devsel_const: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      o_devsel_timing == devsel_medium)
      else $error("select timing not medium");
   // base register and window bounds
   a_base_reserved: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      base_read |=> (o_read_data[31:16] == 16'h0000 && o_read_data[3:0] == 4'h0))
      else $error("base read has stray bits");
   a_base_align: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      o_window_base[19:0] == 20'h0 && o_window_limit[19:0] == 20'hfffff)
      else $error("window not aligned");
   a_base_follow: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (base_write && !i_cfg.byte_enable_n[1] && !i_cfg.byte_enable_n[0]) |=> ##1 o_window_base[31:20] == $past(i_cfg.data[15:4], 2))
      else $error("base not taken");
   a_base_lane: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (base_write && i_cfg.byte_enable_n[1] && !i_cfg.byte_enable_n[0]) |=> $stable(base_field[11:4]))
      else $error("base upper lane written while disabled");
   a_window_track: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      $past(i_arst_n) |-> o_window_base[31:20] == $past(base_field))
      else $error("window base not following field");
   a_limit_follow: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      $past(i_arst_n) |-> o_window_limit[31:20] == $past(i_memory_limit))
      else $error("window limit not following field");
   a_hit_inside: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      o_window_hit |-> ($past(i_secondary_address) >= o_window_base
      && $past(i_secondary_address) <= o_window_limit))
      else $error("window hit outside the bounds");
   // main scenarios
   c_status_read: cover property (@(posedge i_clock) disable iff (!i_arst_n)
      o_read_valid && o_read_data[31]);
   c_clear_flag: cover property (@(posedge i_clock) disable iff (!i_arst_n)
      flags.received_master_abort_flag ##1 !flags.received_master_abort_flag);
   c_window_hit: cover property (@(posedge i_clock) disable iff (!i_arst_n)
      o_window_hit);
   c_set_and_clear: cover property (@(posedge i_clock) disable iff (!i_arst_n)
      set_vec.detected_parity_flag && clr_vec.detected_parity_flag);
   c_lane_skip: cover property (@(posedge i_clock) disable iff (!i_arst_n)
      status_write && i_cfg.byte_enable_n[3]);
endmodule : bridge_secondary_status_membase

// File: verification/sec_bus_model.sv
module sec_bus_model(
   input wire logic i_clock,
   input wire logic [8:0] i_request,
   output logic [8:0] o_lines
);
   timeunit 1ns;
   timeprecision 100ps;
   // bit order: addr pe, data pe, serr_n, perr_n, primary pe, master, ma, ta in, ta out
   // active-low lines idle high as pulled up; each event lasts one cycle
   initial o_lines = 9'h00c;
   always @(posedge i_clock) begin
      o_lines <= i_request ^ 9'h00c;
   end
endmodule : sec_bus_model

// File: verification/testbench.sv
module testbench
   import bridge_sec_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
`define check(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("mismatch %s expected %h seen %h", what, exp, got); end end
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   cfg_req_type cfg = '0;
   logic [8:0] request = 9'h0;
   logic [8:0] lines;
   logic per = 1'b0;
   logic [11:0] limit = 12'h0;
   logic [31:0] address = 32'h0;
   logic [31:0] read_data, window_base, window_limit;
   logic read_valid, window_hit;
   logic [1:0] devsel;
   int n_mismatch = 0;
   int comparisons = 0;
   logic [9:0] ev [9] = '{10'h201, 10'h202, 10'h204, 10'h240, 10'h280, 10'h300, 10'h228, 10'h230, 10'h028};
   logic [15:0] flag [9] = '{16'h8000, 16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0100, 16'h0100, 16'h0};
   logic [31:0] addr_tab [4] = '{32'h12300000, 32'h122fffff, 32'h124fffff, 32'h12500000};
   sec_bus_model partner(.i_clock(clock), .i_request(request), .o_lines(lines));
   bridge_secondary_status_membase dut(.i_clock(clock), .i_arst_n(arst_n), .i_cfg(cfg),
      .i_address_parity_error(lines[0]), .i_data_parity_error(lines[1]),
      .i_secondary_system_error_line_n(lines[2]), .i_secondary_parity_error_line_n(lines[3]),
      .i_primary_parity_error(lines[4]), .i_secondary_master_active(lines[5]),
      .i_master_abort_received(lines[6]), .i_target_abort_received(lines[7]),
      .i_target_abort_signalled(lines[8]), .i_parity_error_response(per), .i_memory_limit(limit),
      .i_secondary_address(address), .o_read_data(read_data), .o_read_valid(read_valid),
      .o_window_base(window_base), .o_window_limit(window_limit), .o_window_hit(window_hit),
      .o_devsel_timing(devsel));
   ////////////////////////////////////////////////////////////////
   initial forever #2 clock = ~clock;
   task automatic complete_run;
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run
   task automatic access(input logic w, input logic [7:0] off, input logic [3:0] be_n, input logic [31:0] d);
      @(posedge clock) #1;
      cfg = '{1'b1, w, off, be_n, d};
      @(posedge clock) #1;
      cfg.valid = 1'b0;
   endtask : access
   task automatic read_check(input logic [7:0] off, input logic [31:0] exp);
      access(1'b0, off, 4'h0, 32'h0);
      `check("read valid", 1'b1, read_valid)
      `check("read data", exp, read_data)
   endtask : read_check
   task automatic fire(input logic [8:0] r);
      @(posedge clock) #1;
      request = r;
      @(posedge clock) #1;
      request = 9'h0;
   endtask : fire
   ////////////////////////////////////////////////////////////////
   initial begin
      #40000;
      n_mismatch++;
      complete_run();
   end
   initial begin
      repeat (6) @(posedge clock);
      #1 arst_n = 1'b1;
      `check("devsel", 2'h1, devsel)
      read_check(status_offset, 32'h02a00000);
      access(1'b1, status_offset, 4'h0, 32'hffffffff);
      read_check(status_offset, 32'h02a00000);
      foreach (ev[k]) begin
         per = ev[k][9];
         fire(ev[k][8:0]);
         read_check(status_offset, {flag[k] | 16'h02a0, 16'h0});
         access(1'b1, status_offset, 4'h0, 32'h0);
         read_check(status_offset, {flag[k] | 16'h02a0, 16'h0});
         access(1'b1, status_offset, 4'h0, {flag[k], 16'h0});
         read_check(status_offset, 32'h02a00000);
      end
      // event lands on the same edge as the clearing write
      fork
         fire(9'h001);
         begin
            @(posedge clock);
            access(1'b1, status_offset, 4'h0, 32'h80000000);
         end
      join
      read_check(status_offset, 32'h82a00000);
      access(1'b1, status_offset, 4'h8, 32'h80000000);
      read_check(status_offset, 32'h82a00000);
      access(1'b1, status_offset, 4'h0, 32'h80000000);
      read_check(status_offset, 32'h02a00000);
      limit = 12'h124;
      access(1'b1, membase_offset, 4'h0, 32'h0000123f);
      read_check(membase_offset, 32'h00001230);
      `check("window base", 32'h12300000, window_base)
      `check("window limit", 32'h124fffff, window_limit)
      foreach (addr_tab[k]) begin
         address = addr_tab[k];
         @(posedge clock) #1;
         `check("window hit", (k % 2) == 0, window_hit)
      end
      access(1'b1, 8'h24, 4'h0, 32'hffffffff);
      `check("read valid", 1'b0, read_valid)
      read_check(8'h24, 32'h0);
      read_check(membase_offset, 32'h00001230);
      access(1'b1, membase_offset, 4'he, 32'h0000abcf);
      read_check(membase_offset, 32'h000012c0);
      `check("window base", 32'h12c00000, window_base)
      complete_run();
   end
endmodule : testbench
